// ==== design/amids_top.sv ====
// Accessory, headset audio and ID sense mode control behind the ULPI pins.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1: Link enables both UART routes before selecting accessory mode.
// R2: Link sets function control to non-driving, full-speed edges before UART.
// R3: Link writes zero to IO power management, picking 3.3V for UART.
// R4: In UART mode DATA0 drives DM and DP is returned on DATA1.
// R5: UART mode switches regulator to the UART level and applies line pull-ups.
// R6: In UART mode the speed select field picks full or low speed edges.
// R7: Link enables speaker switches before selecting accessory mode for audio.
// R8: Audio switches follow their enable bits right after the write completes.
// R9: An ID ground comparator change in synchronous mode sends a receive command.
// R10: An ID ground change in accessory mode raises the DATA3 interrupt.
// R11: Setting the measure-go bit starts an ID resistance conversion.
// R12: Link may poll the measure-go bit, which clears when conversion ends.
// R13: With its interrupt enabled, conversion end sends an alt_int receive command.
// R14: The conversion result is held in the ID conversion register.
// R15: Writing the headset register enters headset audio mode.
// R16: Headset mode outputs session valid, bus power valid and low DATA3.
// R17: Headset mode samples DATA2 to ground the ID pin.
// R18: Headset mode reports ID grounded on DATA4 and floating on DATA5.
// R19: Headset mode DATA6 and DATA7 enable the weak and strong ID pull-ups.
// R20: Headset mode exits like low power mode or by the reset input.
// R21: STP exits the mode; DIR drops, then STP release resumes synchronous mode.
// R22: Accessory mode stops clock and PLL unless clock keep running is set.
// R23: Accessory mode drives interrupt on DATA3 and DATA4 to DATA7 low.
module amids_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ulpi_stp,
  input wire logic [7:0] ulpi_data_in,
  output logic ulpi_dir,
  output logic ulpi_nxt,
  output logic [7:0] ulpi_data_out,
  output logic [7:0] ulpi_data_oe_n,
  input wire amids_pkg::amids_sense_t sense,
  output amids_pkg::amids_ctl_t ctl,
  output amids_pkg::amids_mode_t mode_q
);

  amids_pkg::amids_ulpi_t st_q, st_d;
  amids_pkg::amids_mode_t mode_d;
  amids_pkg::amids_ctl_t ctl_d;
  logic [5:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic [7:0] func_q, func_d;
  logic [7:0] iface_q, iface_d;
  logic [7:0] acc_q, acc_d;
  logic [7:0] hs_q, hs_d;
  logic [7:0] idc_q, idc_d;
  logic [7:0] io_q, io_d;
  logic dir_d, nxt_d;
  logic [7:0] dout_d, oe_d;
  logic id_prev_q, id_pend_q, id_pend_d, rid_pend_q, rid_pend_d;
  logic irq_q, irq_d, start_q, start_d;
  logic conv_busy, conv_done;
  logic [2:0] conv_code;
  logic commit, id_chg, rid_evt, uart_mode, float_flag;
  logic [7:0] rdata, rxcmd;

  // Write, set and clear aliases of one register.
  function automatic logic [7:0] reg_upd(input logic [7:0] cur, input logic [5:0] base,
                                         input logic [5:0] addr, input logic [7:0] wd);
    logic [7:0] res;
    res = cur;
    if (addr == base) begin
      res = wd;
    end else if (addr == 6'(base + amids_pkg::SET_OFS)) begin
      res = cur | wd;
    end else if (addr == 6'(base + amids_pkg::CLR_OFS)) begin
      res = cur & ~wd;
    end
    return res;
  endfunction : reg_upd

  function automatic logic in_grp(input logic [5:0] base, input logic [5:0] addr);
    return (addr == base) || (addr == 6'(base + amids_pkg::SET_OFS)) ||
           (addr == 6'(base + amids_pkg::CLR_OFS));
  endfunction : in_grp

  amids_id_converter u_conv (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(start_q),
    .adc_code(sense.id_adc_code),
    .busy(conv_busy),
    .done(conv_done),
    .code(conv_code)
  );

  // Read data, receive command and status terms.
  always_comb begin
    rdata = 8'h00;
    if (in_grp(amids_pkg::FUNC_CTRL_ADDR, addr_q)) begin
      rdata = func_q;
    end else if (in_grp(amids_pkg::IFACE_CTRL_ADDR, addr_q)) begin
      rdata = iface_q;
    end else if (in_grp(amids_pkg::ACC_CTRL_ADDR, addr_q)) begin
      rdata = acc_q;
    end else if (addr_q == amids_pkg::HEADSET_ADDR) begin
      rdata = hs_q;
    end else if (in_grp(amids_pkg::ID_CONV_ADDR, addr_q)) begin
      rdata = idc_q;
      rdata[amids_pkg::ID_CODE_LSB +: 3] = conv_code; // R14
    end else if (in_grp(amids_pkg::IO_PWR_ADDR, addr_q)) begin
      rdata = io_q;
    end
    rxcmd = 8'h00;
    rxcmd[amids_pkg::RXCMD_ID_BIT] = sense.id_ground_cmp; // R9
    rxcmd[amids_pkg::RXCMD_ALT_BIT] = rid_pend_q; // R13
    commit = (st_q == amids_pkg::U_WSTP) && ulpi_stp;
    id_chg = sense.id_ground_cmp != id_prev_q;
    rid_evt = conv_done && idc_q[amids_pkg::ID_IRQ_EN_BIT];
    uart_mode = (mode_q == amids_pkg::MODE_ACCESSORY) &&
                (acc_q[amids_pkg::TX_ROUTE_BIT] || acc_q[amids_pkg::RX_ROUTE_BIT]);
    float_flag = sense.id_float_cmp && (ctl.id_weak_pullup_en || ctl.id_strong_pullup_en) &&
                 hs_q[amids_pkg::HS_FLOAT_RISE_BIT] && hs_q[amids_pkg::HS_FLOAT_FALL_BIT]; // R18
  end

  // Register file updates.
  always_comb begin
    func_d = func_q;
    iface_d = iface_q;
    acc_d = acc_q;
    hs_d = hs_q;
    idc_d = idc_q;
    io_d = io_q;
    if (conv_done) begin
      idc_d[amids_pkg::ID_GO_BIT] = 1'b0; // R12
    end
    if (commit) begin
      func_d = reg_upd(func_q, amids_pkg::FUNC_CTRL_ADDR, addr_q, wdata_q);
      iface_d = reg_upd(iface_q, amids_pkg::IFACE_CTRL_ADDR, addr_q, wdata_q);
      acc_d = reg_upd(acc_q, amids_pkg::ACC_CTRL_ADDR, addr_q, wdata_q);
      io_d = reg_upd(io_q, amids_pkg::IO_PWR_ADDR, addr_q, wdata_q);
      idc_d = reg_upd(idc_d, amids_pkg::ID_CONV_ADDR, addr_q, wdata_q); // R11
      if (addr_q == amids_pkg::HEADSET_ADDR) begin
        hs_d = wdata_q;
      end
    end
    if ((st_q == amids_pkg::U_EXIT) && !ulpi_stp) begin
      iface_d[amids_pkg::ACC_SEL_BIT] = 1'b0; // R21
      hs_d[amids_pkg::HS_ENTER_BIT] = 1'b0; // R20
    end
    start_d = idc_d[amids_pkg::ID_GO_BIT] && !idc_q[amids_pkg::ID_GO_BIT]; // R11
  end

  // ULPI sequencing, mode entry and exit, events.
  always_comb begin
    st_d = st_q;
    mode_d = mode_q;
    addr_d = addr_q;
    wdata_d = wdata_q;
    dir_d = ulpi_dir;
    nxt_d = 1'b0;
    dout_d = ulpi_data_out;
    oe_d = amids_pkg::ALL_OE_N;
    id_pend_d = id_pend_q;
    rid_pend_d = rid_pend_q;
    irq_d = irq_q;
    if (mode_q == amids_pkg::MODE_SYNC) begin
      id_pend_d = id_pend_d || id_chg; // R9
      rid_pend_d = rid_pend_d || rid_evt; // R13
    end else if (mode_q == amids_pkg::MODE_ACCESSORY) begin
      irq_d = irq_q || id_chg || rid_evt; // R10 R23
    end
    case (st_q)
      amids_pkg::U_IDLE: begin
        if (!ulpi_stp && ulpi_data_in[7:6] == amids_pkg::CMD_WRITE) begin
          addr_d = ulpi_data_in[5:0];
          nxt_d = 1'b1;
          st_d = amids_pkg::U_WCMD;
        end else if (!ulpi_stp && ulpi_data_in[7:6] == amids_pkg::CMD_READ) begin
          addr_d = ulpi_data_in[5:0];
          nxt_d = 1'b1;
          st_d = amids_pkg::U_RCMD;
        end else if (id_pend_q || rid_pend_q) begin
          dir_d = 1'b1;
          st_d = amids_pkg::U_XTA;
        end
      end
      amids_pkg::U_WCMD: begin
        nxt_d = 1'b1;
        st_d = amids_pkg::U_WDATA;
      end
      amids_pkg::U_WDATA: begin
        wdata_d = ulpi_data_in;
        st_d = amids_pkg::U_WSTP;
      end
      amids_pkg::U_WSTP: begin
        if (ulpi_stp) begin
          st_d = amids_pkg::U_IDLE;
          if (iface_d[amids_pkg::ACC_SEL_BIT]) begin
            mode_d = amids_pkg::MODE_ACCESSORY;
            dir_d = 1'b1;
            irq_d = 1'b0;
            st_d = amids_pkg::U_MODE;
          end else if (hs_d[amids_pkg::HS_ENTER_BIT]) begin
            mode_d = amids_pkg::MODE_HEADSET; // R15
            dir_d = 1'b1;
            st_d = amids_pkg::U_MODE;
          end
        end
      end
      amids_pkg::U_RCMD: begin
        dir_d = 1'b1;
        st_d = amids_pkg::U_RTA;
      end
      amids_pkg::U_RTA: begin
        dout_d = rdata;
        oe_d = 8'h00;
        st_d = amids_pkg::U_RDATA;
      end
      amids_pkg::U_RDATA: begin
        dir_d = 1'b0;
        st_d = amids_pkg::U_IDLE;
      end
      amids_pkg::U_XTA: begin
        dout_d = rxcmd;
        oe_d = 8'h00;
        id_pend_d = id_chg;
        rid_pend_d = rid_evt;
        st_d = amids_pkg::U_XDATA;
      end
      amids_pkg::U_XDATA: begin
        dir_d = 1'b0;
        st_d = amids_pkg::U_IDLE;
      end
      amids_pkg::U_MODE: begin
        if (ulpi_stp) begin
          dir_d = 1'b0; // R21
          dout_d = 8'h00;
          st_d = amids_pkg::U_EXIT;
        end else if (mode_q == amids_pkg::MODE_ACCESSORY) begin
          oe_d = amids_pkg::ACC_OE_N; // R23
          dout_d = 8'h00;
          dout_d[3] = irq_d; // R23
          dout_d[1] = acc_q[amids_pkg::RX_ROUTE_BIT] && sense.uart_rx_dp; // R4
        end else begin
          oe_d = amids_pkg::HS_OE_N;
          dout_d = 8'h00; // R16
          dout_d[0] = sense.session_valid_cmp; // R16
          dout_d[1] = sense.bus_power_valid_cmp && hs_q[amids_pkg::HS_VBUS_IRQ_BIT]; // R16
          dout_d[4] = sense.id_ground_cmp; // R18
          dout_d[5] = float_flag; // R18
        end
      end
      amids_pkg::U_EXIT: begin
        if (!ulpi_stp) begin
          mode_d = amids_pkg::MODE_SYNC; // R21
          irq_d = 1'b0;
          // An event in the exit cycle is carried into synchronous mode, not lost.
          id_pend_d = id_pend_d || id_chg; // R9
          rid_pend_d = rid_pend_d || rid_evt; // R13
          st_d = amids_pkg::U_IDLE;
        end
      end
      default: begin
        st_d = amids_pkg::U_IDLE;
      end
    endcase
  end

  // Analog side controls.
  always_comb begin
    ctl_d = ctl;
    ctl_d.uart_tx_dm = (uart_mode && acc_q[amids_pkg::TX_ROUTE_BIT]) ?
                       ulpi_data_in[0] : 1'b1; // R4
    ctl_d.line_pullup_resistors = uart_mode; // R5
    ctl_d.regulator_uart_mode = uart_mode; // R5
    ctl_d.uart_regulator_level = io_q[amids_pkg::UART_REG_BIT]; // R5
    ctl_d.low_speed_edges = func_q[amids_pkg::SPEED_LSB +: 2] == amids_pkg::SPEED_LS; // R6
    ctl_d.left_audio_switch_en = acc_q[amids_pkg::LEFT_SW_BIT]; // R8
    ctl_d.right_audio_switch_en = acc_q[amids_pkg::RIGHT_SW_BIT]; // R8
    ctl_d.id_ground_drive = 1'b0;
    ctl_d.id_weak_pullup_en = 1'b0;
    ctl_d.id_strong_pullup_en = 1'b0;
    if (mode_q == amids_pkg::MODE_HEADSET && st_q == amids_pkg::U_MODE) begin
      ctl_d.id_ground_drive = ulpi_data_in[2]; // R17
      ctl_d.id_weak_pullup_en = ulpi_data_in[6]; // R19
      ctl_d.id_strong_pullup_en = ulpi_data_in[7]; // R19
    end
    ctl_d.clk_out_en = (mode_q != amids_pkg::MODE_ACCESSORY) ||
                       iface_q[amids_pkg::KEEP_CLK_BIT]; // R22
    ctl_d.pll_en = ctl_d.clk_out_en; // R22
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= amids_pkg::U_IDLE;
      mode_q <= amids_pkg::MODE_SYNC; // R20
      addr_q <= 6'h00;
      wdata_q <= 8'h00;
      func_q <= amids_pkg::FUNC_CTRL_RST;
      iface_q <= amids_pkg::IFACE_CTRL_RST;
      acc_q <= amids_pkg::ACC_CTRL_RST;
      hs_q <= amids_pkg::HEADSET_RST;
      idc_q <= amids_pkg::ID_CONV_RST;
      io_q <= amids_pkg::IO_PWR_RST;
      ulpi_dir <= 1'b0;
      ulpi_nxt <= 1'b0;
      ulpi_data_out <= 8'h00;
      ulpi_data_oe_n <= amids_pkg::ALL_OE_N;
      id_prev_q <= 1'b1;
      id_pend_q <= 1'b0;
      rid_pend_q <= 1'b0;
      irq_q <= 1'b0;
      start_q <= 1'b0;
      ctl <= '{uart_tx_dm: 1'b1, clk_out_en: 1'b1, pll_en: 1'b1, default: 1'b0};
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      func_q <= func_d;
      iface_q <= iface_d;
      acc_q <= acc_d;
      hs_q <= hs_d;
      idc_q <= idc_d;
      io_q <= io_d;
      ulpi_dir <= dir_d;
      ulpi_nxt <= nxt_d;
      ulpi_data_out <= dout_d;
      ulpi_data_oe_n <= oe_d;
      id_prev_q <= sense.id_ground_cmp;
      id_pend_q <= id_pend_d;
      rid_pend_q <= rid_pend_d;
      irq_q <= irq_d;
      start_q <= start_d;
      ctl <= ctl_d;
    end
  end

endmodule : amids_top
`default_nettype wire

// ==== design/amids_pkg.sv ====
// Constants, types and carrier structs for the accessory mode and ID sense block.
package amids_pkg;

  localparam int ADDR_W = 6;

  // Register base addresses; each except HEADSET_ADDR has a set and clear alias above it.
  localparam logic [5:0] FUNC_CTRL_ADDR = 6'h04;
  localparam logic [5:0] IFACE_CTRL_ADDR = 6'h07;
  localparam logic [5:0] ACC_CTRL_ADDR = 6'h19;
  localparam logic [5:0] HEADSET_ADDR = 6'h33;
  localparam logic [5:0] ID_CONV_ADDR = 6'h36;
  localparam logic [5:0] IO_PWR_ADDR = 6'h39;
  localparam logic [5:0] SET_OFS = 6'h01;
  localparam logic [5:0] CLR_OFS = 6'h02;

  // Values after reset.
  localparam logic [7:0] FUNC_CTRL_RST = 8'h41;
  localparam logic [7:0] IFACE_CTRL_RST = 8'h00;
  localparam logic [7:0] ACC_CTRL_RST = 8'h00;
  localparam logic [7:0] HEADSET_RST = 8'h00;
  localparam logic [7:0] ID_CONV_RST = 8'h00;
  localparam logic [7:0] IO_PWR_RST = 8'h04;

  // Field positions.
  localparam int SPEED_LSB = 0;
  localparam int LINE_MODE_LSB = 3;
  localparam int ACC_SEL_BIT = 2;
  localparam int KEEP_CLK_BIT = 3;
  localparam int TX_ROUTE_BIT = 2;
  localparam int RX_ROUTE_BIT = 3;
  localparam int LEFT_SW_BIT = 4;
  localparam int RIGHT_SW_BIT = 5;
  localparam int UART_REG_BIT = 2;
  localparam int ID_CODE_LSB = 0;
  localparam int ID_GO_BIT = 3;
  localparam int ID_IRQ_EN_BIT = 4;
  localparam int HS_ENTER_BIT = 0;
  localparam int HS_VBUS_IRQ_BIT = 1;
  localparam int HS_FLOAT_RISE_BIT = 2;
  localparam int HS_FLOAT_FALL_BIT = 3;
  localparam int RXCMD_ID_BIT = 6;
  localparam int RXCMD_ALT_BIT = 7;

  localparam logic [1:0] SPEED_LS = 2'h2;
  localparam logic [1:0] CMD_WRITE = 2'h2;
  localparam logic [1:0] CMD_READ = 2'h3;

  // Data pin direction masks per mode; a zero bit means the pin is driven.
  localparam logic [7:0] ACC_OE_N = 8'h01;
  localparam logic [7:0] HS_OE_N = 8'hC4;
  localparam logic [7:0] ALL_OE_N = 8'hFF;

  // ID resistance conversion time.
  localparam int CLK_PERIOD_PS = 20000;
  localparam int ID_CONV_TIME_NS = 10000;
  localparam int ID_CONV_CYCLES = (ID_CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ID_CNT_W = 10;

  typedef enum logic [1:0] {MODE_SYNC, MODE_ACCESSORY, MODE_HEADSET} amids_mode_t;

  typedef enum logic [3:0] {
    U_IDLE, U_WCMD, U_WDATA, U_WSTP, U_RCMD, U_RTA, U_RDATA,
    U_XTA, U_XDATA, U_MODE, U_EXIT
  } amids_ulpi_t;

  typedef struct packed {
    logic id_ground_cmp;
    logic id_float_cmp;
    logic session_valid_cmp;
    logic bus_power_valid_cmp;
    logic uart_rx_dp;
    logic [2:0] id_adc_code;
  } amids_sense_t;

  typedef struct packed {
    logic uart_tx_dm;
    logic line_pullup_resistors;
    logic regulator_uart_mode;
    logic uart_regulator_level;
    logic low_speed_edges;
    logic left_audio_switch_en;
    logic right_audio_switch_en;
    logic id_ground_drive;
    logic id_weak_pullup_en;
    logic id_strong_pullup_en;
    logic clk_out_en;
    logic pll_en;
  } amids_ctl_t;

endpackage : amids_pkg

// ==== design/amids_id_converter.sv ====
// ID resistance converter: times one conversion and latches the result code.
`timescale 1ns/1ps
`default_nettype none
module amids_id_converter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] adc_code,
  output logic busy,
  output logic done,
  output logic [2:0] code
);

  logic [amids_pkg::ID_CNT_W-1:0] cnt_q, cnt_d;
  logic busy_d, done_d;
  logic [2:0] code_d;

  always_comb begin
    cnt_d = cnt_q;
    busy_d = busy;
    done_d = 1'b0;
    code_d = code;
    if (!busy && start) begin
      busy_d = 1'b1;
      cnt_d = amids_pkg::ID_CNT_W'(amids_pkg::ID_CONV_CYCLES - 1);
    end else if (busy) begin
      if (cnt_q == '0) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        code_d = adc_code;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      code <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      busy <= busy_d;
      done <= done_d;
      code <= code_d;
    end
  end

endmodule : amids_id_converter
`default_nettype wire

// ==== design/amids_top_end.sv ====
// Intentionally left minimal; no design content.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== verification/amids_link_model.sv ====
// Behavioural Link that issues register commands and STP on the ULPI side.
`timescale 1ns/1ps
`default_nettype none
module amids_link_model (
  input wire logic ref_clk,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] bus,
  output logic ulpi_stp,
  output logic [7:0] link_data
);
  int timeouts = 0;
  int gap = 0;
  initial begin
    ulpi_stp = 1'b0;
    link_data = 8'h00;
  end
  // Waits for an edge that sees nxt high (0), dir high (1) or dir low (2).
  task automatic wait_edge(input int sel);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!((sel == 0 && ulpi_nxt) || (sel == 1 && ulpi_dir) || (sel == 2 && !ulpi_dir))
               && n < 40);
    if (n >= 40) timeouts++;
  endtask : wait_edge
  // Never starts a command while the device owns the bus.
  task automatic start_cmd(input logic [7:0] cmd);
    repeat (gap) @(posedge ref_clk);
    @(posedge ref_clk);
    #1;
    if (ulpi_dir) begin
      wait_edge(2);
      #1;
    end
    link_data = cmd;
    wait_edge(0);
    #1;
  endtask : start_cmd
  task automatic reg_write(input logic [5:0] addr, input logic [7:0] val);
    start_cmd({amids_pkg::CMD_WRITE, addr});
    link_data = val;
    wait_edge(0);
    #1 link_data = 8'h00;
    ulpi_stp = 1'b1;
    @(posedge ref_clk);
    #1 ulpi_stp = 1'b0;
  endtask : reg_write
  task automatic reg_read(input logic [5:0] addr, output logic [7:0] val);
    start_cmd({amids_pkg::CMD_READ, addr});
    link_data = ~link_data;
    wait_edge(1);
    @(posedge ref_clk);
    val = bus;
    #1;
  endtask : reg_read
  task automatic drive_pins(input logic [7:0] val);
    @(posedge ref_clk);
    #1 link_data = val;
  endtask : drive_pins
  // Holds STP until the device drops DIR, then releases it.
  task automatic stop_mode();
    @(posedge ref_clk);
    #1 ulpi_stp = 1'b1;
    link_data = 8'h00;
    wait_edge(2);
    #1 ulpi_stp = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : stop_mode
endmodule : amids_link_model
`default_nettype wire

// ==== verification/amids_top_assertions.sv ====
// Concurrent checks on the mode pins of the accessory mode block.
`timescale 1ns/1ps
`default_nettype none
module amids_assert_chk (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ulpi_stp,
  input wire logic [7:0] ulpi_data_in,
  input wire logic ulpi_dir,
  input wire logic ulpi_nxt,
  input wire logic [7:0] ulpi_data_out,
  input wire logic [7:0] ulpi_data_oe_n,
  input wire amids_pkg::amids_sense_t sense,
  input wire amids_pkg::amids_ctl_t ctl,
  input wire amids_pkg::amids_mode_t mode_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic in_acc;
  logic in_hs;
  logic in_sync;
  assign in_acc = mode_q == amids_pkg::MODE_ACCESSORY && ulpi_dir;
  assign in_hs = mode_q == amids_pkg::MODE_HEADSET && ulpi_dir;
  assign in_sync = mode_q == amids_pkg::MODE_SYNC;
  acc_pins_a:
    assert property (in_acc && $past(in_acc) |-> ulpi_data_oe_n == amids_pkg::ACC_OE_N
      && ulpi_data_out[7:4] == 4'h0) else $error("accessory pin map wrong");
  hs_pins_a:
    assert property (in_hs && $past(in_hs) |-> ulpi_data_oe_n == amids_pkg::HS_OE_N
      && !ulpi_data_out[3]) else $error("headset pin map wrong");
  hs_drive_a:
    assert property (in_hs && $past(in_hs) |-> ctl.id_ground_drive == $past(ulpi_data_in[2])
      && ctl.id_weak_pullup_en == $past(ulpi_data_in[6])
      && ctl.id_strong_pullup_en == $past(ulpi_data_in[7])) else $error("ID pin control wrong");
  hs_report_a:
    assert property (in_hs && $past(in_hs) |->
      ulpi_data_out[0] == $past(sense.session_valid_cmp)
      && ulpi_data_out[4] == $past(sense.id_ground_cmp)) else $error("headset status wrong");
  exit_dir_a:
    assert property (!in_sync && ulpi_dir && ulpi_stp |=> !ulpi_dir
      && ulpi_data_oe_n == amids_pkg::ALL_OE_N) else $error("DIR not dropped on STP");
  hold_dir_a:
    assert property (!in_sync && ulpi_dir && !ulpi_stp |=> ulpi_dir && $stable(mode_q))
      else $error("mode left without STP");
  exit_sync_a:
    assert property (!in_sync && !ulpi_dir && !ulpi_stp |=> in_sync)
      else $error("no return to synchronous mode");
  turn_around_a:
    assert property (in_sync && $rose(ulpi_dir) |=> ulpi_data_oe_n == 8'h00
      ##1 (!ulpi_dir && ulpi_data_oe_n == amids_pkg::ALL_OE_N)) else $error("bad turnaround");
  uart_pullup_a:
    assert property (ctl.line_pullup_resistors |-> $past(mode_q) == amids_pkg::MODE_ACCESSORY)
      else $error("line pull-ups outside accessory mode");
  cover property (in_acc);
  cover property (in_hs);
  cover property (in_sync && $rose(ulpi_dir));
endmodule : amids_assert_chk
bind amids_top amids_assert_chk i_chk (.ref_clk(ref_clk), .rst(rst), .ulpi_stp(ulpi_stp),
  .ulpi_data_in(ulpi_data_in), .ulpi_dir(ulpi_dir), .ulpi_nxt(ulpi_nxt),
  .ulpi_data_out(ulpi_data_out), .ulpi_data_oe_n(ulpi_data_oe_n), .sense(sense), .ctl(ctl),
  .mode_q(mode_q));
`default_nettype wire

// ==== verification/accessory_mode_and_id_sense_test.sv ====
// Self-checking bench for the accessory mode and ID sense block.
`timescale 1ns/1ps
`default_nettype none
module accessory_mode_and_id_sense_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic dir;
  logic nxt;
  logic stp;
  logic [7:0] dout;
  logic [7:0] oe_n;
  logic [7:0] ldat;
  wire logic [7:0] bus;
  amids_pkg::amids_sense_t sense = 8'h80;
  amids_pkg::amids_ctl_t ctl;
  amids_pkg::amids_mode_t mode_q;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  // Each data bit carries the device where it drives, the Link elsewhere.
  assign bus = (ldat & oe_n) | (dout & ~oe_n);
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  amids_top i_dut (.ref_clk(ref_clk), .rst(rst), .ulpi_stp(stp), .ulpi_data_in(bus),
    .ulpi_dir(dir), .ulpi_nxt(nxt), .ulpi_data_out(dout), .ulpi_data_oe_n(oe_n),
    .sense(sense), .ctl(ctl), .mode_q(mode_q));
  amids_link_model i_link (.ref_clk(ref_clk), .ulpi_dir(dir), .ulpi_nxt(nxt), .bus(bus),
    .ulpi_stp(stp), .link_data(ldat));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic wait_dir(input int lim);
    int n;
    n = 0;
    while (dir !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    chk(dir, 1'b1);
  endtask : wait_dir
  task automatic t_regs();
    logic [7:0] v;
    logic [5:0] a [7] = '{6'h04, 6'h07, 6'h19, 6'h33, 6'h36, 6'h39, 6'h3C};
    logic [7:0] e [7] = '{8'h41, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    chk({ctl, mode_q}, {12'h803, 2'h0});
    i_link.reg_write(6'h3C, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      i_link.reg_read(a[i], v);
      chk(v, e[i]);
    end
  endtask : t_regs
  task automatic t_id_ground_cmp();
    for (int i = 0; i < 2; i++) begin
      sense.id_ground_cmp = i[0];
      wait_dir(8);
      step(1);
      chk({oe_n, dout[6]}, {8'h00, i[0]});
      step(1);
    end
  endtask : t_id_ground_cmp
  task automatic t_uart(input logic [7:0] fc, input logic [7:0] ic);
    logic [7:0] v;
    i_link.reg_write(6'h04, fc);
    i_link.reg_write(6'h39, 8'h00);
    i_link.reg_write(6'h19, 8'h0C);
    i_link.reg_write(6'h07, ic);
    sense.uart_rx_dp = 1'b1;
    i_link.drive_pins(8'h00);
    step(2);
    chk({ctl.line_pullup_resistors, ctl.regulator_uart_mode, ctl.uart_regulator_level,
      ctl.low_speed_edges, ctl.clk_out_en, ctl.pll_en}, {3'b110, fc[1], ic[3], ic[3]});
    chk({mode_q, ctl.uart_tx_dm, dout[1], oe_n, dout[7:4]}, {4'b0101, 8'h01, 4'h0});
    sense.uart_rx_dp = 1'b0;
    i_link.drive_pins(8'h01);
    step(2);
    chk({ctl.uart_tx_dm, dout[1]}, 2'b10);
    sense.id_ground_cmp = 1'b0;
    step(2);
    chk(dout[3], 1'b1);
    sense.id_ground_cmp = 1'b1;
    i_link.stop_mode();
    chk({mode_q, dir}, 3'h0);
    i_link.reg_read(6'h07, v);
    chk(v, ic & 8'hFB);
  endtask : t_uart
  task automatic t_audio();
    logic [7:0] v;
    i_link.reg_write(6'h04, 8'h48);
    i_link.reg_write(6'h19, 8'h30);
    step(1);
    chk({ctl.left_audio_switch_en, ctl.right_audio_switch_en}, 2'b11);
    i_link.reg_write(6'h07, 8'h04);
    step(2);
    chk({mode_q, ctl.line_pullup_resistors, ctl.left_audio_switch_en}, 4'b0101);
    i_link.stop_mode();
    i_link.reg_write(6'h1B, 8'h10);
    step(1);
    chk({ctl.left_audio_switch_en, ctl.right_audio_switch_en}, 2'b01);
    i_link.reg_read(6'h19, v);
    chk(v, 8'h20);
  endtask : t_audio
  task automatic t_conv();
    logic [7:0] v;
    int t0;
    i_link.gap = 3;
    sense.id_adc_code = 3'h5;
    i_link.reg_write(6'h36, 8'h18);
    t0 = cyc;
    i_link.reg_read(6'h36, v);
    chk(v, 8'h18);
    wait_dir(700);
    chk(cyc - t0 > amids_pkg::ID_CONV_CYCLES - 10 && cyc - t0 < amids_pkg::ID_CONV_CYCLES + 10,
      1'b1);
    step(1);
    chk(dout[7], 1'b1);
    step(1);
    i_link.reg_read(6'h36, v);
    chk(v, 8'h15);
  endtask : t_conv
  task automatic t_head();
    logic [7:0] v;
    i_link.reg_write(6'h33, 8'h0F);
    sense = 8'h70;
    i_link.drive_pins(8'h44);
    step(3);
    chk({mode_q, oe_n}, {2'h2, 8'hC4});
    chk({ctl.id_ground_drive, ctl.id_weak_pullup_en, ctl.id_strong_pullup_en}, 3'b110);
    chk(dout & 8'h3B, 8'h23);
    sense = 8'hC0;
    i_link.drive_pins(8'h80);
    step(3);
    chk({ctl.id_ground_drive, ctl.id_weak_pullup_en, ctl.id_strong_pullup_en}, 3'b001);
    chk(dout & 8'h3B, 8'h30);
    i_link.drive_pins(8'h00);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(4);
    chk({mode_q, dir}, 3'h0);
    i_link.reg_read(6'h33, v);
    chk(v, 8'h00);
  endtask : t_head
  task automatic finish_test();
    error_cnt += i_link.timeouts;
    $display("Errors: %0d Compared: %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    step(12);
    rst = 1'b0;
    t_regs();
    t_id_ground_cmp();
    t_uart(8'h49, 8'h04);
    t_uart(8'h4A, 8'h0C);
    t_audio();
    t_conv();
    t_head();
    finish_test();
  end
endmodule : accessory_mode_and_id_sense_test
`default_nettype wire
